// [src/eepw_link_if.sv]
`timescale 1ns/1ps
interface eepw_link_if;
  logic bit_val;
  logic bit_tgl;
  modport link (output bit_val, output bit_tgl);
  modport core (input bit_val, input bit_tgl);
endinterface

// [src/eepw_link_rx.sv]
`timescale 1ns/1ps
module eepw_link_rx (
  input wire logic scl_clk,
  input wire logic rst,
  input wire logic sda,
  eepw_link_if.link lnk
);

  typedef struct packed {
    logic [1:0] rst_s;
    logic bit_val;
    logic bit_tgl;
  } eepw_rx_t;

  eepw_rx_t q;
  eepw_rx_t n;

  // ---------------------------------------------------------------
  // bit capture on the serial clock
  // ---------------------------------------------------------------
  always_comb
  begin
    n = q;
    n.rst_s = {q.rst_s[0], rst};
    if (q.rst_s[1])
    begin
      n.bit_val = 1'b0;
      n.bit_tgl = 1'b0;
    end
    else
    begin
      // RULE9 - rising edge sampling
      n.bit_val = sda;
      n.bit_tgl = ~q.bit_tgl;
    end
  end

  always_ff @(posedge scl_clk)
  begin
    q <= n;
  end

  // value stays put until the next rising edge, a toggle marks it
  assign lnk.bit_val = q.bit_val;
  assign lnk.bit_tgl = q.bit_tgl;

endmodule

// [src/eepw_pkg.sv]
package eepw_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int REF_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 5000000;
  // longest time, so rounded down
  localparam int PROG_CYCLES = PROG_TIME_NS / REF_PERIOD_NS;

  // ---------------------------------------------------------------
  // array and page layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_BITS = 5;
  localparam int BYTE_BITS = 8;

  // ---------------------------------------------------------------
  // device address word fields
  // ---------------------------------------------------------------
  // value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h5;
  localparam int TYPE_LSB = 4;
  localparam int SEL_LSB = 1;
  localparam int RW_POS = 0;

  // ---------------------------------------------------------------
  // byte position inside a transfer
  // ---------------------------------------------------------------
  localparam logic [1:0] BYTE_DEV = 2'h0;
  localparam logic [1:0] BYTE_HI = 2'h1;
  localparam logic [1:0] BYTE_LO = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RX = 2'h1,
    ST_ACK = 2'h3,
    ST_PROG = 2'h2
  } eepw_state_t;

endpackage

// [src/eepw_top.sv]
// Notes on behaviour
// RULE1 - three select bits of the address word must equal the straps
// RULE2 - controller sends an 8-bit address word: type code, select bits
// RULE3 - last address bit: one means read, zero means write
// RULE4 - match is acknowledged low; mismatch stays silent and idles
// RULE5 - data changes only with clock low; else start or stop
// RULE6 - start is data falling while clock high, before any command
// RULE7 - stop is data rising while clock high
// RULE8 - eight-bit words, each received one acknowledged on ninth clock
// RULE9 - sample data on clock rise, change output after clock fall
// RULE10 - data line is only pulled low or released
// RULE11 - idle after power-up, and after stop once work is done
// RULE12 - write-lock high blocks all programming
// RULE13 - 32-byte pages, 12 or 13 address bits
// RULE14 - byte write: device, address, one data byte, stop
// RULE15 - stop after a write starts a program cycle of 5 ms at most
// RULE16 - bus ignored and silent while programming
// RULE17 - page write: up to 31 more data bytes, each acknowledged
// RULE18 - only low five address bits count up, wrapping in page
// RULE19 - address word is acknowledged only after programming ends
// RULE20 - controller recovers with up to nine clocks, then a start
// RULE21 - two address bytes, high first; excess bits ignored
`timescale 1ns/1ps
module eepw_top #(
  parameter int ADDR_W = eepw_pkg::ADDR_W,
  parameter int PROG_CYCLES = eepw_pkg::PROG_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic SELECT_STRAP_BIT0,
  input wire logic SELECT_STRAP_BIT1,
  input wire logic SELECT_STRAP_BIT2,
  input wire logic WRITE_LOCK,
  input wire logic [ADDR_W-1:0] PEEK_ADDR,
  output logic [7:0] PEEK_DATA,
  output logic STANDBY,
  output logic BUSY
);

  localparam int MEM_DEPTH = 1 << ADDR_W;
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam int PB = eepw_pkg::PAGE_BITS;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] wp_s;
    logic [1:0][2:0] strap_s;
    logic [1:0] tgl_s;
    logic scl_d;
    logic sda_d;
    logic tgl_last;
    eepw_pkg::eepw_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] byte_idx;
    logic rw;
    logic drive;
    logic ack_rise;
    logic [ADDR_W-1:0] addr;
    logic [eepw_pkg::PAGE_BYTES-1:0] mask;
    logic [eepw_pkg::PAGE_BYTES-1:0][7:0] pbuf;
    logic [TW-1:0] timer;
  } eepw_core_t;

  eepw_core_t q;
  eepw_core_t n;

  logic [7:0] mem [MEM_DEPTH];
  logic mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0] mem_wd;

  logic [2:0] strap;
  logic [7:0] rx_byte;
  logic scl_hi;
  logic bit_ev;
  logic start_ev;
  logic stop_ev;
  logic byte_done;
  logic dev_ev;
  logic dev_hit;
  logic data_ev;
  logic [ADDR_W-1:0] addr_wrap;

  eepw_link_if lnk ();

  eepw_link_rx u_rx (
    .scl_clk(SCL),
    .rst(RST),
    .sda(SDA_I),
    .lnk(lnk)
  );

  // ---------------------------------------------------------------
  // bus events seen from the reference clock
  // ---------------------------------------------------------------
  assign strap = {SELECT_STRAP_BIT2, SELECT_STRAP_BIT1, SELECT_STRAP_BIT0};
  assign rx_byte = {q.shreg[6:0], lnk.bit_val};
  assign scl_hi = q.scl_s[1];
  assign bit_ev = q.tgl_s[1] != q.tgl_last;
  // RULE5 - edges with clock high
  // RULE6 - start detection
  assign start_ev = scl_hi && q.scl_d && q.sda_d && !q.sda_s[1];
  // RULE7 - stop detection
  assign stop_ev = scl_hi && q.scl_d && !q.sda_d && q.sda_s[1];
  assign byte_done = q.st == eepw_pkg::ST_RX && bit_ev
    && q.bitcnt == eepw_pkg::LAST_BIT;
  assign dev_ev = byte_done && q.byte_idx == eepw_pkg::BYTE_DEV;
  // RULE1 - select bit compare
  assign dev_hit =
    rx_byte[7:eepw_pkg::TYPE_LSB] == eepw_pkg::DEV_TYPE
    && rx_byte[eepw_pkg::SEL_LSB+:3] == q.strap_s[1];
  assign data_ev = byte_done && q.byte_idx == eepw_pkg::BYTE_DATA;
  assign addr_wrap = {q.addr[ADDR_W-1:PB], q.addr[PB-1:0] + 5'h1};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = q;
    mem_we = 1'b0;
    mem_addr = '0;
    mem_wd = '0;
    n.scl_s = {q.scl_s[0], SCL};
    n.sda_s = {q.sda_s[0], SDA_I};
    n.wp_s = {q.wp_s[0], WRITE_LOCK};
    n.strap_s = {q.strap_s[0], strap};
    n.tgl_s = {q.tgl_s[0], lnk.bit_tgl};
    n.scl_d = q.scl_s[1];
    n.sda_d = q.sda_s[1];
    n.tgl_last = q.tgl_s[1];

    unique case (q.st)
      eepw_pkg::ST_IDLE:
      begin
        n.drive = 1'b0;
      end
      eepw_pkg::ST_RX:
      begin
        if (bit_ev)
        begin
          n.shreg = rx_byte;
          n.bitcnt = q.bitcnt + 4'h1;
        end
        // RULE8 - full word taken
        if (byte_done)
        begin
          n.st = eepw_pkg::ST_ACK;
          if (q.byte_idx != eepw_pkg::BYTE_DATA)
          begin
            n.byte_idx = q.byte_idx + 2'h1;
          end
          unique case (q.byte_idx)
            eepw_pkg::BYTE_DEV:
            begin
              // RULE4 - silent on mismatch
              if (!dev_hit)
              begin
                n.st = eepw_pkg::ST_IDLE;
              end
              // RULE3 - operation select bit
              n.rw = rx_byte[eepw_pkg::RW_POS];
              n.mask = '0;
            end
            eepw_pkg::BYTE_HI:
            begin
              // RULE21 - high address byte
              n.addr[ADDR_W-1:8] = rx_byte[ADDR_W-9:0];
            end
            eepw_pkg::BYTE_LO:
            begin
              // RULE14 - low address byte
              n.addr[7:0] = rx_byte;
            end
            eepw_pkg::BYTE_DATA:
            begin
              // RULE17 - page buffer fill
              n.pbuf[q.addr[PB-1:0]] = rx_byte;
              n.mask[q.addr[PB-1:0]] = 1'b1;
              // RULE18 - in-page increment
              n.addr[PB-1:0] = q.addr[PB-1:0] + 5'h1;
            end
          endcase
        end
      end
      eepw_pkg::ST_ACK:
      begin
        // RULE9 - drive after clock fall
        if (!q.drive && !q.ack_rise && !scl_hi)
        begin
          n.drive = 1'b1;
        end
        if (q.drive && bit_ev)
        begin
          n.ack_rise = 1'b1;
        end
        // RULE8 - release after ninth clock
        if (q.ack_rise && !scl_hi)
        begin
          n.drive = 1'b0;
          n.ack_rise = 1'b0;
          n.bitcnt = '0;
          n.st = q.rw ? eepw_pkg::ST_IDLE : eepw_pkg::ST_RX;
        end
      end
      eepw_pkg::ST_PROG:
      begin
        n.drive = 1'b0;
        n.timer = q.timer + TW'(1);
        // RULE13 - page commit into array
        if (q.timer < TW'(eepw_pkg::PAGE_BYTES))
        begin
          mem_we = q.mask[q.timer[PB-1:0]];
          mem_addr = {q.addr[ADDR_W-1:PB], q.timer[PB-1:0]};
          mem_wd = q.pbuf[q.timer[PB-1:0]];
        end
        // RULE11 - idle once programmed
        if (q.timer == TW'(PROG_CYCLES - 1))
        begin
          n.st = eepw_pkg::ST_IDLE;
          n.mask = '0;
          n.timer = '0;
        end
      end
    endcase

    // RULE16 - bus ignored while programming
    // RULE19 - polling gets no answer
    if (q.st != eepw_pkg::ST_PROG)
    begin
      if (start_ev)
      begin
        n.st = eepw_pkg::ST_RX;
        n.bitcnt = '0;
        n.byte_idx = eepw_pkg::BYTE_DEV;
        n.drive = 1'b0;
        n.ack_rise = 1'b0;
        n.rw = 1'b0;
        n.mask = '0;
      end
      else if (stop_ev)
      begin
        n.drive = 1'b0;
        n.ack_rise = 1'b0;
        n.st = eepw_pkg::ST_IDLE;
        // RULE15 - program cycle start
        // RULE12 - lock blocks programming
        if (|q.mask && !q.wp_s[1])
        begin
          n.st = eepw_pkg::ST_PROG;
          n.timer = '0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // state registers and array
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      q <= '0;
    end
    else if (CE)
    begin
      q <= n;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (CE && mem_we)
    begin
      mem[mem_addr] <= mem_wd;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      PEEK_DATA <= '0;
    end
    else if (CE)
    begin
      PEEK_DATA <= mem[PEEK_ADDR];
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // RULE10 - open-drain, only low
  assign SDA_O = 1'b0;
  assign SDA_OE_N = ~q.drive;
  assign STANDBY = q.st == eepw_pkg::ST_IDLE;
  assign BUSY = q.st == eepw_pkg::ST_PROG;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST || !CE);

  sequence s_stop_write;
    stop_ev && q.st != eepw_pkg::ST_PROG && |q.mask && !q.wp_s[1];
  endsequence

  sequence s_prog_last;
    q.st == eepw_pkg::ST_PROG && q.timer == TW'(PROG_CYCLES - 1);
  endsequence

  sequence s_ack_on;
    $rose(q.drive);
  endsequence

  chk_prog_entry: assert property ( // RULE15
    s_stop_write |=> q.st == eepw_pkg::ST_PROG && q.timer == '0)
    else $error("write stop did not start programming");

  chk_prog_bound: assert property ( // RULE15
    q.st == eepw_pkg::ST_PROG |-> q.timer < TW'(PROG_CYCLES))
    else $error("program cycle ran too long");

  chk_prog_done: assert property ( // RULE11
    s_prog_last |=> q.st == eepw_pkg::ST_IDLE && STANDBY)
    else $error("no return to standby after programming");

  chk_prog_silent: assert property ( // RULE16
    q.st == eepw_pkg::ST_PROG |-> SDA_OE_N && !$rose(q.drive))
    else $error("line driven while programming");

  chk_lock_holds: assert property ( // RULE12
    stop_ev && q.wp_s[1] && q.st != eepw_pkg::ST_PROG
      |=> q.st == eepw_pkg::ST_IDLE)
    else $error("programming started under write lock");

  chk_start_arms: assert property ( // RULE6
    start_ev && q.st != eepw_pkg::ST_PROG
      |=> q.st == eepw_pkg::ST_RX && q.bitcnt == '0
        && q.byte_idx == eepw_pkg::BYTE_DEV)
    else $error("start did not arm address reception");

  chk_miss_idle: assert property ( // RULE4
    dev_ev && !dev_hit && !start_ev && !stop_ev
      |=> q.st == eepw_pkg::ST_IDLE ##1 SDA_OE_N)
    else $error("mismatched address not ignored");

  chk_hit_ack: assert property ( // RULE1
    dev_ev && dev_hit && !start_ev && !stop_ev
      |=> q.st == eepw_pkg::ST_ACK)
    else $error("matching address not acknowledged");

  chk_addr_wrap: assert property ( // RULE18
    data_ev && !start_ev && !stop_ev |=> q.addr == $past(addr_wrap))
    else $error("address did not wrap within page");

  chk_ack_fall: assert property ( // RULE9
    s_ack_on |-> !$past(q.scl_s[1]))
    else $error("acknowledge driven while clock high");

  chk_ack_hold: assert property ( // RULE8
    s_ack_on |-> SDA_OE_N == 1'b0 [*2])
    else $error("acknowledge not held");

endmodule

// [testbench/eepw_ctl_model.sv]
`timescale 1ns/1ps
module eepw_ctl_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic tick;

  // --------------------------------------------------------------
  // free time base; scl stands still between frames
  // --------------------------------------------------------------
  initial
  begin
    tick = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
    forever #16 tick = ~tick;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge tick);
    #2;
  endtask

  task automatic pulse(input int n);
    repeat (n)
    begin
      wt(4);
      scl = 1'b0;
      wt(4);
      scl = 1'b1;
    end
    wt(4);
  endtask

  task automatic start();
    sda_low = 1'b0;
    wt(8);
    scl = 1'b1;
    wt(8);
    sda_low = 1'b1;
    wt(8);
    scl = 1'b0;
    wt(8);
  endtask

  task automatic clock_bit(input logic b, output logic seen);
    sda_low = ~b;
    wt(8);
    scl = 1'b1;
    wt(4);
    seen = sda;
    wt(4);
    scl = 1'b0;
    wt(8);
  endtask

  task automatic bits8(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(d[i], s);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    bits8(d);
    clock_bit(1'b1, ack);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    wt(8);
    scl = 1'b1;
    wt(8);
    sda_low = 1'b0;
    wt(8);
  endtask

  task automatic recover(output int n);
    logic s;
    n = 0;
    s = 1'b0;
    while (s !== 1'b1 && n < 9)
    begin
      clock_bit(1'b1, s);
      n++;
    end
  endtask
endmodule

// [testbench/serial_eeprom_write_path_tb.sv]
`timescale 1ns/1ps
module serial_eeprom_write_path_tb;
  localparam int PROG = 400;
  localparam int LIMIT = 60000;
  logic REF_CLK;
  logic RST;
  logic CE;
  logic SCL;
  logic SDA_I;
  logic SDA_O;
  logic SDA_OE_N;
  logic WRITE_LOCK;
  logic STANDBY;
  logic BUSY;
  logic [12:0] PEEK_ADDR;
  logic [7:0] PEEK_DATA;
  logic [2:0] strap;
  logic ctl_low;
  logic [7:0] dev_w;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int busy_run = 0;
  int busy_len = 0;

  // --------------------------------------------------------------
  // wire with pull-up
  // --------------------------------------------------------------
  assign SDA_I = ctl_low ? 1'b0 : (SDA_OE_N ? 1'b1 : SDA_O);
  assign dev_w = {eepw_pkg::DEV_TYPE, strap, 1'b0};

  eepw_top #(.ADDR_W(13), .PROG_CYCLES(PROG)) DUT (
    .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .SCL(SCL),
    .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
    .SELECT_STRAP_BIT0(strap[0]), .SELECT_STRAP_BIT1(strap[1]),
    .SELECT_STRAP_BIT2(strap[2]), .WRITE_LOCK(WRITE_LOCK),
    .PEEK_ADDR(PEEK_ADDR), .PEEK_DATA(PEEK_DATA),
    .STANDBY(STANDBY), .BUSY(BUSY)
  );
  eepw_ctl_model ctl (.scl(SCL), .sda_low(ctl_low), .sda(SDA_I));

  initial
  begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  // --------------------------------------------------------------
  // program length and hang guard
  // --------------------------------------------------------------
  always @(posedge REF_CLK)
  begin
    cycles <= cycles + 1;
    if (BUSY === 1'b1)
      busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
    if (cycles == LIMIT)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_bit(input string what, input logic e,
                           input logic g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_num(input string what, input int e, input int g);
    check_count++;
    if (g != e)
    begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic ref_wait(input int n);
    repeat (n) @(posedge REF_CLK);
    #2;
  endtask

  task automatic peek(input logic [12:0] a, input logic [7:0] e);
    ref_wait(1);
    PEEK_ADDR = a;
    ref_wait(2);
    check_byte("peek data", e, PEEK_DATA);
  endtask

  task automatic write_seq(input logic [15:0] a, input logic [7:0] d[$]);
    logic ack;
    ctl.start();
    ctl.send_byte(dev_w, ack);
    check_bit("device ack", 1'b0, ack);
    ctl.send_byte(a[15:8], ack);
    check_bit("addr high ack", 1'b0, ack);
    ctl.send_byte(a[7:0], ack);
    check_bit("addr low ack", 1'b0, ack);
    foreach (d[i])
    begin
      ctl.send_byte(d[i], ack);
      check_bit("data ack", 1'b0, ack);
    end
    ctl.stop();
  endtask

  task automatic poll(input logic busy_exp);
    logic ack;
    int n;
    n = 0;
    do
    begin
      ctl.start();
      ctl.send_byte(dev_w, ack);
      ctl.stop();
      if (n == 0)
        check_bit("first poll", busy_exp, ack);
      n++;
    end while (ack !== 1'b0 && n < 20);
    check_bit("poll ack", 1'b0, ack);
    check_bit("busy at ack", 1'b0, BUSY);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    check_bit("oe_n idle", 1'b1, SDA_OE_N);
    check_bit("sda level", 1'b0, SDA_O);
    check_bit("standby idle", 1'b1, STANDBY);
    check_bit("busy idle", 1'b0, BUSY);
  endtask

  task automatic t_byte_write();
    write_seq(16'h0123, '{8'hA5});
    check_bit("busy after stop", 1'b1, BUSY);
    check_bit("standby in program", 1'b0, STANDBY);
    poll(1'b1);
    check_num("program length", PROG, busy_len);
    check_bit("standby after", 1'b1, STANDBY);
    peek(13'h0123, 8'hA5);
  endtask

  task automatic t_bad_address();
    logic [7:0] bad[4];
    logic ack;
    bad[0] = {eepw_pkg::DEV_TYPE, strap ^ 3'h1, 1'b0};
    bad[1] = {eepw_pkg::DEV_TYPE, strap ^ 3'h2, 1'b0};
    bad[2] = {eepw_pkg::DEV_TYPE, strap ^ 3'h4, 1'b0};
    bad[3] = {~eepw_pkg::DEV_TYPE, strap, 1'b0};
    foreach (bad[i])
    begin
      ctl.start();
      ctl.send_byte(bad[i], ack);
      check_bit("foreign ack", 1'b1, ack);
      check_bit("foreign standby", 1'b1, STANDBY);
      ctl.stop();
    end
  endtask

  task automatic t_page_wrap();
    logic [7:0] d[$];
    for (int i = 0; i < 33; i++)
      d.push_back(8'h40 + 8'(i));
    write_seq(16'hE15E, d);
    // freeze ten cycles while programming
    ref_wait(1);
    CE = 1'b0;
    ref_wait(10);
    CE = 1'b1;
    poll(1'b1);
    check_num("frozen program length", PROG + 10, busy_len);
    peek(13'h015E, 8'h60);
    peek(13'h015F, 8'h41);
    peek(13'h0140, 8'h42);
    peek(13'h015D, 8'h5F);
  endtask

  task automatic t_write_lock();
    ref_wait(1);
    WRITE_LOCK = 1'b1;
    write_seq(16'h0123, '{8'h3C});
    ref_wait(4);
    check_bit("busy when locked", 1'b0, BUSY);
    peek(13'h0123, 8'hA5);
    WRITE_LOCK = 1'b0;
  endtask

  task automatic t_read_bit();
    logic ack;
    ctl.start();
    ctl.send_byte(dev_w | 8'h01, ack);
    check_bit("read ack", 1'b0, ack);
    ctl.stop();
    ref_wait(4);
    check_bit("no program on read", 1'b0, BUSY);
  endtask

  task automatic t_recover();
    int n;
    ctl.start();
    ctl.bits8(dev_w);
    ctl.recover(n);
    check_num("recovery clocks", 2, n);
    ctl.start();
    ctl.stop();
    ref_wait(4);
    check_bit("standby after stop", 1'b1, STANDBY);
  endtask

  initial
  begin
    RST = 1'b1;
    CE = 1'b1;
    WRITE_LOCK = 1'b0;
    PEEK_ADDR = 13'h0000;
    strap = 3'h5;
    // link side resets only on serial clock edges
    fork
      repeat (20) @(posedge REF_CLK);
      ctl.pulse(3);
    join
    #2;
    RST = 1'b0;
    ctl.pulse(3);
    ref_wait(4);
    t_reset();
    t_byte_write();
    t_bad_address();
    t_page_wrap();
    t_write_lock();
    t_read_bit();
    t_recover();
    tally_and_finish();
  end
endmodule
